// >>> hdl/arb_result_formatter.sv
// Result formatter: builds the half-word stream into the latest result
// register and raises a DMA request per stored word, with register map.
// Assumes conversion results arrive as stable levels on the data inputs.
//
// What this block does
// - Normal order: each enabled channel result stored in turn per trigger.
// - User order: sequence slots and channel status choose and repeat.
// - Touch mode 1 or 3 emits X then Y per touch trigger.
// - Touch mode 2 emits X, Y, pressure A, pressure B.
// - With labels, X carries label 0 and Y label 1.
// - Calibration spans never enter the result stream.
// - Averaging or rate keep layout; non-touch triggers add no touch words.
// - Pen sensing does not alter the stream layout.
// - Interleaved pattern repeats every power-of-two triggers; averaging places it.
// - Pen sensing on and no contact: touch words are all zero.
// - Pen sensing on and contact: touch words pass with labels.
// - Labels off: touch words pass without labels, unless pen sensing is on with no contact (then all zero).
// - Guard enable protects the configuration registers from writes.
// - Guarded write sets violation flag and records target offset.
// - Reading the violation register clears the violation flag.
// - Unlisted offsets are reserved: ignored on write, zero on read.
// - Each word is a right-aligned half-word, label in top four bits.
// - A DMA request accompanies every new stored word.
// - Trigger counter wraps at the rate; touch words follow classic ones.
//
// Chosen here: the plain strobed port.
module arb_result_formatter
   import arb_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input wire logic trig_i,
   input wire logic [NCH-1:0][RES_W-1:0] chan_data_i,
   input wire logic [RES_W-1:0] touch_x_i,
   input wire logic [RES_W-1:0] touch_y_i,
   input wire logic [RES_W-1:0] press_a_i,
   input wire logic [RES_W-1:0] press_b_i,
   input wire logic [RES_W-1:0] x_cal_i,
   input wire logic [RES_W-1:0] y_cal_i,
   input wire logic pen_contact_live_i,
   output logic [HW_W-1:0] latest_result_o,
   output logic dma_req_o,
   output logic busy_o,
   output logic cal_req_o
);
   localparam arb_state_t S_RST = '{acr: ACR_RST, st: ST_IDLE,
                                    default: '0};

   arb_state_t s_q;
   arb_state_t s_d;
   logic guarded;
   logic emit;
   logic sel;
   logic last;
   logic tnow;
   logic tag;
   logic pen_sense_enable;
   logic user_order_enable;
   logic [1:0] touch_mode_select;
   logic [3:0] slot;
   logic [3:0] ch;
   logic [3:0] cdr_idx;
   logic cdr_hit;
   logic [RES_W-1:0] tval;
   logic [HW_W-1:0] word;
   logic [TCNT_W-1:0] fmask;
   logic [TCNT_W-1:0] avpos;

   function automatic logic is_guarded(input logic [7:0] a);
      return a == OFF_MR || a == OFF_SEQR || a == OFF_CHER ||
             a == OFF_CHDR || a == OFF_EMR || a == OFF_CWR ||
             a == OFF_ACR || a == OFF_TSMR || a == OFF_TRGR;
   endfunction

   always_comb
   begin
      s_d = s_q;
      s_d.dma = 1'b0;
      s_d.cal = 1'b0;
      s_d.rdata = '0;
      emit = 1'b0;
      sel = 1'b0;
      last = 1'b0;
      tnow = 1'b0;
      slot = '0;
      ch = '0;
      tval = '0;
      word = '0;
      tag = s_q.emr[EMR_TAG];
      pen_sense_enable = s_q.tsmr[TS_PEN];
      user_order_enable = s_q.mr[MR_USER_ORDER_ENABLE];
      touch_mode_select = s_q.tsmr[TS_MODE_LSB +: 2];
      fmask = TCNT_W'((32'h1 << s_q.tsmr[TS_FREQ_LSB +: 4]) - 1);
      avpos = TCNT_W'((32'h1 << s_q.tsmr[TS_AV_LSB +: 2]) - 1) & fmask;
      guarded = s_q.wp_en && is_guarded(reg_addr_i);
      cdr_hit = reg_addr_i >= OFF_CDR0 && reg_addr_i <= OFF_CDR_LAST &&
                reg_addr_i[1:0] == 2'h0;
      cdr_idx = 4'((reg_addr_i - OFF_CDR0) >> 2);

      if (reg_wr_i && guarded)
      begin
         s_d.wp_flag = 1'b1;
         s_d.wp_src = reg_addr_i;
      end
      else if (reg_wr_i)
      begin
         case (reg_addr_i)
            OFF_CR: s_d.cal = reg_wdata_i[CR_CAL];
            OFF_MR: s_d.mr = reg_wdata_i;
            OFF_SEQR: s_d.seq = reg_wdata_i[15:0];
            OFF_CHER: s_d.chsr = s_q.chsr | reg_wdata_i[NCH-1:0];
            OFF_CHDR: s_d.chsr = s_q.chsr & ~reg_wdata_i[NCH-1:0];
            OFF_IER: s_d.imr = s_q.imr | reg_wdata_i;
            OFF_IDR: s_d.imr = s_q.imr & ~reg_wdata_i;
            OFF_EMR: s_d.emr = reg_wdata_i;
            OFF_CWR: s_d.cwr = reg_wdata_i;
            OFF_ACR: s_d.acr = reg_wdata_i;
            OFF_TSMR: s_d.tsmr = reg_wdata_i;
            OFF_TRGR: s_d.trgr = reg_wdata_i;
            OFF_WPMR: s_d.wp_en = reg_wdata_i[WP_EN];
            default: ;
         endcase
      end

      if (reg_rd_i)
      begin
         case (reg_addr_i)
            OFF_MR: s_d.rdata = s_q.mr;
            OFF_SEQR: s_d.rdata = 32'(s_q.seq);
            OFF_CHSR: s_d.rdata = 32'(s_q.chsr);
            OFF_LCDR:
            begin
               s_d.rdata = 32'(s_q.lcdr);
               s_d.drdy = 1'b0;
            end
            OFF_IMR: s_d.rdata = s_q.imr;
            OFF_ISR: s_d.rdata = (32'(s_q.drdy) << ISR_DRDY) |
                                 (32'(pen_contact_live_i) << ISR_PEN_CONTACT_LIVE);
            OFF_OVER: s_d.rdata = '0;
            OFF_EMR: s_d.rdata = s_q.emr;
            OFF_CWR: s_d.rdata = s_q.cwr;
            OFF_ACR: s_d.rdata = s_q.acr;
            OFF_TSMR: s_d.rdata = s_q.tsmr;
            // Spans appear only here, never in the stream
            OFF_XPOS: s_d.rdata = 32'(s_q.xr) |
                                  (32'(x_cal_i) << CAL_LSB);
            OFF_Y_POSITION_VALUE: s_d.rdata = 32'(s_q.yr) |
                                  (32'(y_cal_i) << CAL_LSB);
            OFF_PRESS: s_d.rdata = 32'(s_q.pa) |
                                   (32'(s_q.pb) << PRESS_B_LSB);
            OFF_TRGR: s_d.rdata = s_q.trgr;
            OFF_WPMR: s_d.rdata = 32'(s_q.wp_en);
            OFF_WPSR:
            begin
               s_d.rdata = 32'(s_q.wp_flag) |
                           (32'(s_q.wp_src) << WPS_SRC_LSB);
               s_d.wp_flag = 1'b0;
            end
            default:
            begin
               if (cdr_hit && cdr_idx < 4'(NCH))
                  s_d.rdata = 32'(chan_data_i[cdr_idx]);
               else
                  s_d.rdata = '0;
            end
         endcase
      end

      case (s_q.st)
         ST_IDLE:
         begin
            // Triggers that land while a walk runs are dropped
            if (trig_i)
            begin
               s_d.st = ST_CLASSIC;
               s_d.idx = '0;
               tnow = touch_mode_select != TS_OFF &&
                      s_q.tcnt == avpos;
               s_d.tcnt = (s_q.tcnt + 1'b1) & fmask;
               s_d.tpend = tnow;
               if (tnow)
               begin
                  s_d.xr = touch_x_i;
                  s_d.yr = touch_y_i;
                  s_d.pa = press_a_i;
                  s_d.pb = press_b_i;
               end
            end
         end
         ST_CLASSIC:
         begin
            if (user_order_enable)
            begin
               slot = s_q.seq[s_q.idx[1:0]*SLOT_W +: SLOT_W];
               sel = s_q.chsr[s_q.idx] && slot < 4'(NCH);
               ch = slot;
               last = s_q.idx == 4'(NSLOT - 1);
            end
            else
            begin
               sel = s_q.chsr[s_q.idx];
               ch = s_q.idx;
               last = s_q.idx == 4'(NCH - 1);
            end
            if (sel)
            begin
               emit = 1'b1;
               word = HW_W'(chan_data_i[ch]);
               if (tag)
                  word = word | (HW_W'(ch) << LBL_LSB);
            end
            s_d.idx = s_q.idx + 4'h1;
            if (last)
            begin
               s_d.idx = '0;
               s_d.tstep = '0;
               s_d.st = s_q.tpend ? ST_TOUCH : ST_IDLE;
            end
         end
         ST_TOUCH:
         begin
            case (s_q.tstep)
               2'h0: tval = s_q.xr;
               2'h1: tval = s_q.yr;
               2'h2: tval = s_q.pa;
               default: tval = s_q.pb;
            endcase
            emit = 1'b1;
            word = HW_W'(tval);
            if (tag)
               word = word | (HW_W'(s_q.tstep) << LBL_LSB);
            // Pen sense masks values only, layout stays fixed
            if (pen_sense_enable && !pen_contact_live_i)
               word = '0;
            last = (s_q.tstep == TSTEP_Y &&
                    touch_mode_select != TS_PRESS) ||
                   s_q.tstep == TSTEP_B;
            s_d.tstep = s_q.tstep + 2'h1;
            if (last)
               s_d.st = ST_IDLE;
         end
         default: s_d.st = ST_IDLE;
      endcase

      // Store wins over a same-cycle read clear of the ready flag
      if (emit)
      begin
         s_d.lcdr = word;
         s_d.dma = 1'b1;
         s_d.drdy = 1'b1;
      end

      if (reg_wr_i && reg_addr_i == OFF_CR && reg_wdata_i[CR_SWRST])
         s_d = S_RST;
      s_d.busy = s_d.st != ST_IDLE;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
         s_q <= S_RST;
      else
         s_q <= s_d;
   end

   assign reg_rdata_o = s_q.rdata;
   assign latest_result_o = s_q.lcdr;
   assign dma_req_o = s_q.dma;
   assign busy_o = s_q.busy;
   assign cal_req_o = s_q.cal;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);

   sequence two_words;
      dma_req_o ##1 dma_req_o ##1 !dma_req_o;
   endsequence

   sequence four_words;
      dma_req_o [*4] ##1 !dma_req_o;
   endsequence

   sequence touch_start;
      s_q.st == ST_TOUCH && s_q.tstep == 2'h0;
   endsequence

   a_xy_pair: assert property (
      touch_start ##0 (touch_mode_select != TS_PRESS &&
      !(reg_wr_i && reg_addr_i == OFF_CR)) |=> two_words)
      else $error("position pair not two words");

   a_press_quad: assert property (
      touch_start ##0 (touch_mode_select == TS_PRESS &&
      !(reg_wr_i && reg_addr_i == OFF_CR)) |=> four_words)
      else $error("pressure mode not four words");

   a_touch_label: assert property (
      s_q.st == ST_TOUCH && tag && !pen_sense_enable &&
      !reg_wr_i |=> latest_result_o[15:12] == {2'h0, $past(s_q.tstep)})
      else $error("touch label wrong");

   a_pen_mask: assert property (
      s_q.st == ST_TOUCH && pen_sense_enable && !pen_contact_live_i &&
      !reg_wr_i |=> dma_req_o && latest_result_o == '0)
      else $error("touch word not masked without pen");

   a_no_label: assert property (
      dma_req_o && !$past(tag) |-> latest_result_o[15:12] == 4'h0)
      else $error("label bits set with labels off");

   a_classic_word: assert property (
      s_q.st == ST_CLASSIC && !user_order_enable &&
      s_q.chsr[s_q.idx] && !tag && !reg_wr_i |=> dma_req_o &&
      latest_result_o == HW_W'($past(chan_data_i[s_q.idx])))
      else $error("classic result not stored");

   a_guard_flag: assert property (
      reg_wr_i && guarded |=> s_q.wp_flag &&
      s_q.wp_src == $past(reg_addr_i))
      else $error("violation not recorded");

   a_guard_hold: assert property (
      reg_wr_i && guarded && reg_addr_i == OFF_MR |=> $stable(s_q.mr))
      else $error("guarded mode register changed");

   a_guard_clear: assert property (
      reg_rd_i && reg_addr_i == OFF_WPSR |=> !s_q.wp_flag &&
      reg_rdata_o[0] == $past(s_q.wp_flag))
      else $error("violation flag not cleared by read");

   a_reserved_zero: assert property (
      reg_rd_i && reg_addr_i == 8'h0c |=> reg_rdata_o == '0)
      else $error("reserved offset reads nonzero");

   a_rate_gate: assert property (
      s_q.st == ST_IDLE && trig_i && touch_mode_select != TS_OFF &&
      s_q.tcnt != avpos && !reg_wr_i |=> !s_q.tpend)
      else $error("touch words scheduled off pattern");

   a_rate_hit: assert property (
      s_q.st == ST_IDLE && trig_i && touch_mode_select != TS_OFF &&
      s_q.tcnt == avpos && !reg_wr_i |=> s_q.tpend)
      else $error("touch words missing on pattern slot");

   // A soft reset may clear the word without a request, so writes are left out
   a_store_request: assert property (
      latest_result_o != $past(latest_result_o) && !$past(reg_wr_i)
      |-> dma_req_o)
      else $error("stored word without request");

   a_pen_pass: assert property (
      s_q.st == ST_TOUCH && tag && pen_sense_enable && pen_contact_live_i &&
      !reg_wr_i |=> latest_result_o[15:12] == {2'h0, $past(s_q.tstep)})
      else $error("touch label lost with pen contact");

   a_guard_touch: assert property (
      reg_wr_i && guarded && reg_addr_i == OFF_TSMR |=> $stable(s_q.tsmr))
      else $error("guarded touch register changed");

   a_slot_skip: assert property (
      s_q.st == ST_CLASSIC && user_order_enable &&
      !s_q.chsr[s_q.idx] && !reg_wr_i |=> !dma_req_o)
      else $error("disabled slot produced a word");

   a_walk_end: assert property (
      s_q.st == ST_CLASSIC && !user_order_enable &&
      s_q.idx == 4'(NCH - 1) && !s_q.tpend && !reg_wr_i |=>
      s_q.st == ST_IDLE && !busy_o)
      else $error("normal walk did not end after last channel");
endmodule

// >>> shared/arb_pkg.sv
// Constants, field layout and state types of the result formatter.
// Assumes a byte-addressed 8-bit offset from the register port.
package arb_pkg;
   localparam int RES_W = 10;
   localparam int NCH = 12;
   localparam int NSLOT = 4;
   localparam int SLOT_W = 4;
   localparam int HW_W = 16;
   localparam int LBL_LSB = 12;
   localparam int TCNT_W = 16;
   localparam logic [7:0] OFF_CR = 8'h00;
   localparam logic [7:0] OFF_MR = 8'h04;
   localparam logic [7:0] OFF_SEQR = 8'h08;
   localparam logic [7:0] OFF_CHER = 8'h10;
   localparam logic [7:0] OFF_CHDR = 8'h14;
   localparam logic [7:0] OFF_CHSR = 8'h18;
   localparam logic [7:0] OFF_LCDR = 8'h20;
   localparam logic [7:0] OFF_IER = 8'h24;
   localparam logic [7:0] OFF_IDR = 8'h28;
   localparam logic [7:0] OFF_IMR = 8'h2c;
   localparam logic [7:0] OFF_ISR = 8'h30;
   localparam logic [7:0] OFF_OVER = 8'h3c;
   localparam logic [7:0] OFF_EMR = 8'h40;
   localparam logic [7:0] OFF_CWR = 8'h44;
   localparam logic [7:0] OFF_CDR0 = 8'h50;
   localparam logic [7:0] OFF_CDR_LAST = 8'h7c;
   localparam logic [7:0] OFF_ACR = 8'h94;
   localparam logic [7:0] OFF_TSMR = 8'hb0;
   localparam logic [7:0] OFF_XPOS = 8'hb4;
   localparam logic [7:0] OFF_Y_POSITION_VALUE = 8'hb8;
   localparam logic [7:0] OFF_PRESS = 8'hbc;
   localparam logic [7:0] OFF_TRGR = 8'hc0;
   localparam logic [7:0] OFF_WPMR = 8'he4;
   localparam logic [7:0] OFF_WPSR = 8'he8;
   localparam int CR_SWRST = 0;
   localparam int CR_CAL = 2;
   localparam int MR_USER_ORDER_ENABLE = 31;
   localparam int TS_MODE_LSB = 0;
   localparam int TS_AV_LSB = 4;
   localparam int TS_FREQ_LSB = 8;
   localparam int TS_PEN = 24;
   localparam int EMR_TAG = 24;
   localparam int WP_EN = 0;
   localparam int WPS_SRC_LSB = 8;
   localparam int ISR_DRDY = 24;
   localparam int ISR_PEN_CONTACT_LIVE = 31;
   localparam int CAL_LSB = 16;
   localparam int PRESS_B_LSB = 16;
   localparam logic [31:0] ACR_RST = 32'h00000100;
   localparam logic [1:0] TS_OFF = 2'h0;
   localparam logic [1:0] TS_PRESS = 2'h2;
   localparam logic [1:0] TSTEP_Y = 2'h1;
   localparam logic [1:0] TSTEP_B = 2'h3;

   typedef enum logic [1:0] {ST_IDLE, ST_CLASSIC, ST_TOUCH} arb_seq_t;

   typedef struct packed {
      logic [31:0] mr;
      logic [15:0] seq;
      logic [NCH-1:0] chsr;
      logic [31:0] emr;
      logic [31:0] cwr;
      logic [31:0] acr;
      logic [31:0] tsmr;
      logic [31:0] trgr;
      logic [31:0] imr;
      logic wp_en;
      logic wp_flag;
      logic [7:0] wp_src;
      logic [RES_W-1:0] xr;
      logic [RES_W-1:0] yr;
      logic [RES_W-1:0] pa;
      logic [RES_W-1:0] pb;
      logic [HW_W-1:0] lcdr;
      logic drdy;
      logic dma;
      logic cal;
      logic busy;
      logic [31:0] rdata;
      arb_seq_t st;
      logic [3:0] idx;
      logic [1:0] tstep;
      logic tpend;
      logic [TCNT_W-1:0] tcnt;
   } arb_state_t;
endpackage

// >>> bench/arb_dma_sink.sv
// Model of the DMA read channel that drains the latest result register.
// Assumes a request pulse and its word share one cycle after the clock edge.
module arb_dma_sink
   import arb_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic dma_req_i,
   input wire logic [HW_W-1:0] data_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // Bench reads and empties this directly; no back-pressure exists
   logic [HW_W-1:0] q[$];

   always @(posedge core_clk_i)
   begin
      if (resetn_i && dma_req_i)
      begin
         q.push_back(data_i);
      end
   end
endmodule

// >>> bench/testbench.sv
// Self-checking bench of the result formatter and its register map.
// Assumes the DMA sink model and the formatter package are compiled first.
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
   n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module testbench
   import arb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed
   {
      logic wr;
      logic [7:0] wa;
      logic [31:0] d;
      logic [7:0] ra;
      logic [31:0] e;
   } arb_row_t;
   logic clk, rstn, wr, rd, trig, pen, busy, cal, dma;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, r;
   logic [NCH-1:0][RES_W-1:0] chan;
   logic [RES_W-1:0] tx, ty, pa, pb, cx, cy;
   logic [HW_W-1:0] res;
   logic [HW_W-1:0] exp_q[$];
   int n_mismatch, checks_done, i;
   // Reset values first, then write and read-back pairs, last a channel data read
   arb_row_t rows[20] = '{
      '{1'b0, 8'h00, 32'h0, 8'h04, 32'h0},
      '{1'b0, 8'h00, 32'h0, 8'h08, 32'h0},
      '{1'b0, 8'h00, 32'h0, 8'h18, 32'h0},
      '{1'b0, 8'h00, 32'h0, 8'h20, 32'h0},
      '{1'b0, 8'h00, 32'h0, 8'h94, 32'h100},
      '{1'b0, 8'h00, 32'h0, 8'hb0, 32'h0},
      '{1'b0, 8'h00, 32'h0, 8'hc0, 32'h0},
      '{1'b0, 8'h00, 32'h0, 8'he4, 32'h0},
      '{1'b0, 8'h00, 32'h0, 8'he8, 32'h0},
      '{1'b0, 8'h00, 32'h0, 8'h3c, 32'h0},
      '{1'b1, 8'h0c, 32'hffffffff, 8'h0c, 32'h0},
      '{1'b1, 8'h18, 32'hfff, 8'h18, 32'h0},
      '{1'b1, 8'h40, 32'h01000000, 8'h40, 32'h01000000},
      '{1'b1, 8'h10, 32'h809, 8'h18, 32'h809},
      '{1'b1, 8'h94, 32'h5, 8'h94, 32'h5},
      '{1'b1, 8'hc0, 32'h3, 8'hc0, 32'h3},
      '{1'b1, 8'h24, 32'h11, 8'h2c, 32'h11},
      '{1'b1, 8'h28, 32'h1, 8'h2c, 32'h10},
      '{1'b1, 8'h44, 32'h0abc0123, 8'h44, 32'h0abc0123},
      '{1'b0, 8'h00, 32'h0, 8'h64, 32'h45}};
   logic [7:0] gofs[9] = '{OFF_MR, OFF_SEQR, OFF_CHER, OFF_CHDR, OFF_EMR,
      OFF_CWR, OFF_ACR, OFF_TSMR, OFF_TRGR};

   arb_result_formatter arb_result_formatter_i (.core_clk_i(clk),
      .resetn_i(rstn), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .trig_i(trig),
      .chan_data_i(chan), .touch_x_i(tx), .touch_y_i(ty), .press_a_i(pa),
      .press_b_i(pb), .x_cal_i(cx), .y_cal_i(cy),
      .pen_contact_live_i(pen), .latest_result_o(res), .dma_req_o(dma),
      .busy_o(busy), .cal_req_o(cal));
   arb_dma_sink arb_dma_sink_i (.core_clk_i(clk), .resetn_i(rstn),
      .dma_req_i(dma), .data_i(res));

   task test_done();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // A second pulse lands while busy and must leave no trace
   task pulse_trig(input logic twice);
      int k;
      @(posedge clk);
      trig <= 1'b1;
      @(posedge clk);
      trig <= twice;
      @(posedge clk);
      trig <= 1'b0;
      #1 `CHK("busy in walk", 1'b1, busy)
      for (k = 0; k < 100; k++)
      begin
         @(posedge clk);
         #1;
         if (busy === 1'b0)
            break;
      end
      if (k == 100)
      begin
         n_mismatch++;
         test_done();
      end
      // The sink takes the last word one edge after busy falls
      repeat (2) @(posedge clk);
   endtask
   task ex(input logic [3:0] l, input logic [9:0] d);
      exp_q.push_back({l, 2'b00, d});
   endtask
   task check_q();
      int j;
      `CHK("word count", exp_q.size(), arb_dma_sink_i.q.size())
      for (j = 0; j < exp_q.size() && j < arb_dma_sink_i.q.size(); j++)
         `CHK("stored word", exp_q[j], arb_dma_sink_i.q[j])
      exp_q.delete();
      arb_dma_sink_i.q.delete();
   endtask

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial
   begin
      {rstn, wr, rd, trig, pen, addr, wdata} = '0;
      {tx, ty, pa, pb, cx, cy} = {10'h111, 10'h222, 10'h333, 10'h0ab,
         10'h3ff, 10'h3fe};
      for (i = 0; i < NCH; i++)
         chan[i] = 10'h040 + 10'(i);
      n_mismatch = 0;
      checks_done = 0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      foreach (rows[n])
      begin
         if (rows[n].wr)
            wr_reg(rows[n].wa, rows[n].d);
         rd_reg(rows[n].ra, r);
         `CHK("register", rows[n].e, r)
      end
      // Channels 0, 3 and 11 enabled, labels on, no touch
      pulse_trig(1'b1);
      ex(4'h0, chan[0]);
      ex(4'h3, chan[3]);
      ex(4'hb, chan[11]);
      check_q();
      // Slots 0 and 3 active, both naming channel 5
      wr_reg(OFF_SEQR, 32'h5925);
      wr_reg(OFF_MR, 32'h80000000);
      pulse_trig(1'b0);
      ex(4'h5, chan[5]);
      ex(4'h5, chan[5]);
      check_q();
      wr_reg(OFF_MR, 32'h0);
      wr_reg(OFF_CHDR, 32'hfff);
      wr_reg(OFF_TSMR, 32'h2);
      pulse_trig(1'b0);
      ex(4'h0, tx);
      ex(4'h1, ty);
      ex(4'h2, pa);
      ex(4'h3, pb);
      check_q();
      wr_reg(OFF_EMR, 32'h0);
      for (i = 1; i < 4; i += 2)
      begin
         wr_reg(OFF_TSMR, 32'(i));
         pulse_trig(1'b0);
         ex(4'h0, tx);
         ex(4'h0, ty);
         check_q();
      end
      wr_reg(OFF_EMR, 32'h01000000);
      wr_reg(OFF_TSMR, 32'h01000002);
      pulse_trig(1'b0);
      repeat (4) exp_q.push_back(16'h0000);
      check_q();
      @(posedge clk) pen <= 1'b1;
      pulse_trig(1'b0);
      ex(4'h0, tx);
      ex(4'h1, ty);
      ex(4'h2, pa);
      ex(4'h3, pb);
      check_q();
      rd_reg(OFF_ISR, r);
      `CHK("ready and pen", 32'h81000000, r)
      rd_reg(OFF_LCDR, r);
      `CHK("latest word", {16'h0, 4'h3, 2'b00, pb}, r)
      rd_reg(OFF_ISR, r);
      `CHK("ready cleared", 32'h80000000, r)
      // Rate of two triggers, averaging kept at zero, labels off
      wr_reg(OFF_EMR, 32'h0);
      wr_reg(OFF_CHER, 32'h1);
      wr_reg(OFF_TSMR, 32'h101);
      pulse_trig(1'b0);
      pulse_trig(1'b0);
      `CHK("interleave count", 4, arb_dma_sink_i.q.size())
      `CHK("classic first", {4'h0, 2'b00, chan[0]}, arb_dma_sink_i.q[0])
      `CHK("touch next", {4'h0, 2'b00, tx}, arb_dma_sink_i.q[1])
      `CHK("next classic", {4'h0, 2'b00, chan[0]}, arb_dma_sink_i.q[3])
      arb_dma_sink_i.q.delete();
      // Rate of four triggers, averaging puts the touch words on the second
      wr_reg(OFF_TSMR, 32'h211);
      repeat (4) pulse_trig(1'b0);
      `CHK("average count", 6, arb_dma_sink_i.q.size())
      `CHK("average slot", {4'h0, 2'b00, tx}, arb_dma_sink_i.q[2])
      arb_dma_sink_i.q.delete();
      wr_reg(OFF_CR, 32'h4);
      #1 `CHK("calibration pulse", 1'b1, cal)
      repeat (20) @(posedge clk);
      `CHK("calibration words", 0, arb_dma_sink_i.q.size())
      rd_reg(OFF_XPOS, r);
      `CHK("x span", {6'h0, cx, 6'h0, tx}, r)
      wr_reg(OFF_WPMR, 32'h1);
      foreach (gofs[n])
      begin
         wr_reg(gofs[n], 32'hffffffff);
         rd_reg(OFF_WPSR, r);
         `CHK("guard status", {16'h0, gofs[n], 8'h01}, r)
      end
      rd_reg(OFF_WPSR, r);
      `CHK("guard flag cleared", 1'b0, r[0])
      rd_reg(OFF_MR, r);
      `CHK("guarded mode", 32'h0, r)
      rd_reg(OFF_TSMR, r);
      `CHK("guarded touch", 32'h211, r)
      wr_reg(OFF_WPMR, 32'h0);
      wr_reg(OFF_CR, 32'h1);
      rd_reg(OFF_ACR, r);
      `CHK("soft reset analog", 32'h100, r)
      rd_reg(OFF_TSMR, r);
      `CHK("soft reset touch", 32'h0, r)
      wr_reg(OFF_EMR, 32'h01000000);
      @(posedge clk) rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      rd_reg(OFF_EMR, r);
      `CHK("hard reset ext", 32'h0, r)
      test_done();
   end
endmodule
